// *** branch_unit.sv ***
// execution unit for false, index and link branches
`timescale 1ns/1ps
module branch_unit
    import branch_unit_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    // request from fetch
    input  wire logic        START,
    input  wire logic [31:0] INSTR,
    input  wire logic [31:0] PROGRAM_STATUS_WORD,
    // register file read port, combinational read
    output logic      [3:0]  REG_RD_ADDR,
    input  wire logic [15:0] REG_RD_DATA,
    // register file write port
    output logic             REG_WR_EN,
    output logic      [3:0]  REG_WR_ADDR,
    output logic      [15:0] REG_WR_DATA,
    // result
    output logic             BUSY,
    output logic             DONE,
    output logic             BRANCH_TAKEN,
    output logic             ILLEGAL,
    output logic      [31:0] NEW_PSW
);

    // *****************************************************************
    // state
    // *****************************************************************
    ctx_t        st;
    ctx_t        next_st;
    instr_t      req;
    logic [3:0]  mask;
    logic        cc_clear;
    logic        reg_form;
    logic [15:0] opnd;
    logic [15:0] step_sum;
    logic        step_greater;

    assign req = instr_t'(INSTR);

    // mask test on the incoming request, cc bits sit at PROGRAM_STATUS_WORD[19:16]
    always_comb begin
        mask     = req.r1;
        cc_clear = (PROGRAM_STATUS_WORD[PSW_CC_LSB +: 4] & mask) == 4'h0;
    end

    index_step_unit u_step (
        .count   (st.count),
        .incr    (st.incr),
        .limit   (REG_RD_DATA),
        .sum     (step_sum),
        .greater (step_greater)
    );

    // *****************************************************************
    // operand path
    // *****************************************************************
    // register forms take the register itself; indexed forms add A
    always_comb begin
        reg_form = (st.ins.op == OP_BF_REGISTER) ||
                   (st.ins.op == OP_CALL_REGISTER);
        if (reg_form) begin
            opnd = REG_RD_DATA;
        end else if (st.ins.fld == NO_INDEX) begin
            opnd = st.ins.addr;
        end else begin
            opnd = st.ins.addr + REG_RD_DATA;
        end
    end

    // read address by phase; index regs wrap inside the 16-entry file
    always_comb begin
        case (st.phase)
            P_CNT:   REG_RD_ADDR = st.ins.r1;
            P_INC:   REG_RD_ADDR = st.ins.r1 + REG_STEP_ONE;
            P_LIM:   REG_RD_ADDR = st.ins.r1 + REG_STEP_TWO;
            default: REG_RD_ADDR = st.ins.fld;
        endcase
    end

    // *****************************************************************
    // sequencer
    // *****************************************************************
    always_comb begin
        next_st = st;
        case (st.phase)
            P_IDLE: begin
                if (START) begin
                    next_st.ins     = req;
                    next_st.psw_hi  = PROGRAM_STATUS_WORD[31:16];
                    next_st.ia      = PROGRAM_STATUS_WORD[15:0];
                    next_st.wr      = 1'b0;
                    next_st.taken   = 1'b0;
                    next_st.illegal = 1'b0;
                    next_st.phase   = P_OPND;
                    case (req.op)
                        OP_BF_BACK_SHORT: begin
                            next_st.taken   = cc_clear;
                            next_st.next_ia = cc_clear
                                ? PROGRAM_STATUS_WORD[15:0] - {11'h000, req.fld, 1'b0}
                                : PROGRAM_STATUS_WORD[15:0] + STEP_SHORT;
                            next_st.phase   = P_DONE;
                        end
                        OP_BF_FWD_SHORT: begin
                            next_st.taken   = cc_clear;
                            next_st.next_ia = cc_clear
                                ? PROGRAM_STATUS_WORD[15:0] + {11'h000, req.fld, 1'b0}
                                : PROGRAM_STATUS_WORD[15:0] + STEP_SHORT;
                            next_st.phase   = P_DONE;
                        end
                        OP_BF_REGISTER, OP_BF_INDEXED,
                        OP_INDEX_HIGH, OP_INDEX_LOW_EQ,
                        OP_CALL_REGISTER, OP_CALL_INDEXED: begin
                            next_st.taken = cc_clear;
                        end
                        default: begin
                            // unknown code leaves the address alone
                            next_st.illegal = 1'b1;
                            next_st.next_ia = PROGRAM_STATUS_WORD[15:0];
                            next_st.phase   = P_DONE;
                        end
                    endcase
                end
            end
            P_OPND: begin
                next_st.base  = opnd;
                next_st.phase = P_DONE;
                case (st.ins.op)
                    OP_BF_REGISTER: begin
                        next_st.next_ia = st.taken ? opnd
                                        : st.ia + STEP_SHORT;
                    end
                    OP_BF_INDEXED: begin
                        next_st.next_ia = st.taken ? opnd
                                        : st.ia + STEP_LONG;
                    end
                    OP_CALL_REGISTER: begin
                        // link value is built from the old address
                        next_st.wr      = 1'b1;
                        next_st.wr_data = st.ia + STEP_SHORT;
                        next_st.taken   = 1'b1;
                        next_st.next_ia = opnd;
                    end
                    OP_CALL_INDEXED: begin
                        next_st.wr      = 1'b1;
                        next_st.wr_data = st.ia + STEP_LONG;
                        next_st.taken   = 1'b1;
                        next_st.next_ia = opnd;
                    end
                    default: begin
                        next_st.phase = P_CNT;
                    end
                endcase
            end
            P_CNT: begin
                next_st.count = REG_RD_DATA;
                next_st.phase = P_INC;
            end
            P_INC: begin
                next_st.incr  = REG_RD_DATA;
                next_st.phase = P_LIM;
            end
            P_LIM: begin
                next_st.wr      = 1'b1;
                next_st.wr_data = step_sum;
                if (st.ins.op == OP_INDEX_HIGH) begin
                    next_st.taken = step_greater;
                end else begin
                    next_st.taken = !step_greater;
                end
                next_st.next_ia = ((st.ins.op == OP_INDEX_HIGH) ==
                                   step_greater)
                                ? st.base
                                : st.ia + STEP_LONG;
                next_st.phase   = P_DONE;
            end
            P_DONE: begin
                next_st.phase = P_IDLE;
            end
            default: begin
                next_st.phase = P_IDLE;
            end
        endcase
    end

    // single register stage for the whole context
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // *****************************************************************
    // outputs
    // *****************************************************************
    // cc and the rest of the upper half pass through untouched
    always_comb begin
        BUSY         = st.phase != P_IDLE;
        DONE         = st.phase == P_DONE;
        BRANCH_TAKEN = st.taken;
        ILLEGAL      = st.illegal;
        NEW_PSW      = {st.psw_hi, st.next_ia};
        REG_WR_EN    = (st.phase == P_DONE) && st.wr;
        REG_WR_ADDR  = st.ins.r1;
        REG_WR_DATA  = st.wr_data;
    end

    // *****************************************************************
    // checks
    // *****************************************************************
    property p_false_skip;
        @(posedge CLK) disable iff (!RESET_N)
        START && !BUSY && req.op == OP_BF_FWD_SHORT &&
        ((PROGRAM_STATUS_WORD[PSW_CC_LSB +: 4] & req.r1) != 4'h0)
        |=> DONE && !BRANCH_TAKEN &&
            NEW_PSW[15:0] == $past(PROGRAM_STATUS_WORD[15:0]) + 16'h0002;
    endproperty
    a_false_skip: assert property (p_false_skip)
        else $error("false branch taken with a true condition");

    property p_cc_kept;
        @(posedge CLK) disable iff (!RESET_N)
        START && !BUSY |=> NEW_PSW[31:16] == $past(PROGRAM_STATUS_WORD[31:16]);
    endproperty
    a_cc_kept: assert property (p_cc_kept)
        else $error("condition code changed by branch");

    // the upper half must not move while the branch is worked out
    property p_cc_hold;
        @(posedge CLK) disable iff (!RESET_N)
        BUSY |=> $stable(NEW_PSW[31:16]);
    endproperty
    a_cc_hold: assert property (p_cc_hold)
        else $error("status upper half moved while busy");

    property p_mask_zero;
        @(posedge CLK) disable iff (!RESET_N)
        START && !BUSY && req.op == OP_BF_BACK_SHORT && req.r1 == 4'h0
        |=> DONE && BRANCH_TAKEN;
    endproperty
    a_mask_zero: assert property (p_mask_zero)
        else $error("zero mask did not branch");

    property p_back;
        @(posedge CLK) disable iff (!RESET_N)
        DONE && st.ins.op == OP_BF_BACK_SHORT && BRANCH_TAKEN
        |-> NEW_PSW[15:0] == st.ia - {11'h000, st.ins.fld, 1'b0};
    endproperty
    a_back: assert property (p_back)
        else $error("backward short target wrong");

    property p_fwd;
        @(posedge CLK) disable iff (!RESET_N)
        DONE && st.ins.op == OP_BF_FWD_SHORT && BRANCH_TAKEN
        |-> NEW_PSW[15:0] == st.ia + {11'h000, st.ins.fld, 1'b0};
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("forward short target wrong");

    property p_reg_target;
        @(posedge CLK) disable iff (!RESET_N)
        st.phase == P_OPND && st.ins.op == OP_BF_REGISTER && st.taken
        |=> DONE && NEW_PSW[15:0] == $past(REG_RD_DATA);
    endproperty
    a_reg_target: assert property (p_reg_target)
        else $error("register false branch target wrong");

    property p_idx_skip;
        @(posedge CLK) disable iff (!RESET_N)
        DONE && st.ins.op == OP_BF_INDEXED && !BRANCH_TAKEN
        |-> NEW_PSW[15:0] == st.ia + 16'h0004;
    endproperty
    a_idx_skip: assert property (p_idx_skip)
        else $error("indexed false skip not plus four");

    property p_count_wb;
        @(posedge CLK) disable iff (!RESET_N)
        st.phase == P_LIM
        |=> REG_WR_EN && REG_WR_DATA == $past(st.count) + $past(st.incr);
    endproperty
    a_count_wb: assert property (p_count_wb)
        else $error("index count not written back");

    property p_high;
        @(posedge CLK) disable iff (!RESET_N)
        DONE && st.ins.op == OP_INDEX_HIGH
        |-> NEW_PSW[15:0] == (BRANCH_TAKEN ? st.base : st.ia + 16'h0004);
    endproperty
    a_high: assert property (p_high)
        else $error("index high next address wrong");

    property p_low;
        @(posedge CLK) disable iff (!RESET_N)
        st.phase == P_LIM && st.ins.op == OP_INDEX_LOW_EQ &&
        $signed(step_sum) <= $signed(REG_RD_DATA)
        |=> BRANCH_TAKEN && NEW_PSW[15:0] == st.base;
    endproperty
    a_low: assert property (p_low)
        else $error("index low-equal did not branch");

    property p_link;
        @(posedge CLK) disable iff (!RESET_N)
        DONE && st.ins.op == OP_CALL_REGISTER
        |-> REG_WR_EN && REG_WR_DATA == st.ia + 16'h0002 &&
            REG_WR_ADDR == st.ins.r1;
    endproperty
    a_link: assert property (p_link)
        else $error("link value wrong");

endmodule

// *** branch_unit_pkg.sv ***
// constants and types for the false-branch, index-branch and link unit
// Operation
// - branch-on-false taken only when condition code AND mask is all zeros
// - branch-on-false never alters the condition code field
// - an all-zero mask makes the false branch unconditional
// - taken backward short branch: address = location counter minus 2*D
// - taken forward short branch: address = location counter plus 2*D
// - decode short back, short forward, register forms; mask bits 8-11
// - not taken: advance 2 for short/register forms, 4 for indexed
// - taken register form loads second register, indexed A plus index
// - index forms add increment to count, write back, compare with limit
// - index-high branches when updated count exceeds limit, else adds 4
// - index-low-equal branches when count at most limit, else adds 4
// - link writes address plus 2 or 4 to first register, then branches
package branch_unit_pkg;

    // *****************************************************************
    // opcodes
    // *****************************************************************
    localparam logic [7:0] OP_BF_BACK_SHORT = 8'h22;
    localparam logic [7:0] OP_BF_FWD_SHORT  = 8'h23;
    localparam logic [7:0] OP_BF_REGISTER   = 8'h03;
    localparam logic [7:0] OP_BF_INDEXED    = 8'h43;
    localparam logic [7:0] OP_INDEX_HIGH    = 8'hC0;
    localparam logic [7:0] OP_INDEX_LOW_EQ  = 8'hC1;
    localparam logic [7:0] OP_CALL_REGISTER = 8'h01;
    localparam logic [7:0] OP_CALL_INDEXED  = 8'h41;

    // *****************************************************************
    // field positions, steps and reset values
    // *****************************************************************
    localparam int          PSW_CC_LSB   = 16;
    localparam logic [3:0]  NO_INDEX     = 4'h0;
    localparam logic [15:0] STEP_SHORT   = 16'h0002;
    localparam logic [15:0] STEP_LONG    = 16'h0004;
    localparam logic [3:0]  REG_STEP_ONE = 4'h1;
    localparam logic [3:0]  REG_STEP_TWO = 4'h2;
    localparam logic [15:0] ZERO_HALF    = 16'h0000;

    // *****************************************************************
    // types
    // *****************************************************************
    typedef enum logic [2:0] {
        P_IDLE,
        P_OPND,
        P_CNT,
        P_INC,
        P_LIM,
        P_DONE
    } phase_t;

    // instruction as it lies in memory, opcode in the top byte
    typedef struct packed {
        logic [7:0]  op;
        logic [3:0]  r1;
        logic [3:0]  fld;
        logic [15:0] addr;
    } instr_t;

    typedef struct packed {
        phase_t      phase;
        instr_t      ins;
        logic [15:0] psw_hi;
        logic [15:0] ia;
        logic [15:0] base;
        logic [15:0] count;
        logic [15:0] incr;
        logic [15:0] next_ia;
        logic [15:0] wr_data;
        logic        wr;
        logic        taken;
        logic        illegal;
    } ctx_t;

endpackage

// *** index_step_unit.sv ***
// signed count step and limit compare for the index branches
`timescale 1ns/1ps
module index_step_unit
    import branch_unit_pkg::*;
(
    // operands
    input  wire logic [15:0] count,
    input  wire logic [15:0] incr,
    input  wire logic [15:0] limit,
    // results
    output logic      [15:0] sum,
    output logic             greater
);

    // sum wraps modulo 16 bits, compare is two's complement
    always_comb begin
        sum     = count + incr;
        greater = $signed(sum) > $signed(limit);
    end

endmodule

// *** reg_file_model.sv ***
// behavioural general register file facing the branch unit
`timescale 1ns/1ps
module reg_file_model (
    // clock
    input  wire logic        clk,
    // read port, answered in the same cycle
    input  wire logic [3:0]  rd_addr,
    output logic      [15:0] rd_data,
    // write port from the unit
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    // preload port from the bench
    input  wire logic        ld_en,
    input  wire logic [3:0]  ld_addr,
    input  wire logic [15:0] ld_data
);
    // *****************************************************************
    // storage
    // *****************************************************************
    logic [15:0] regs [16];

    // combinational read, as the unit samples it in the address cycle
    assign rd_data = regs[rd_addr];

    // preload wins; the bench never loads while the unit runs
    always_ff @(posedge clk) begin
        if (ld_en) begin
            regs[ld_addr] <= ld_data;
        end else if (wr_en) begin
            regs[wr_addr] <= wr_data;
        end
    end
endmodule

// *** tb_top.sv ***
// self-checking bench for the false, index and link branch unit
`timescale 1ns/1ps
module tb_top
    import branch_unit_pkg::*;
;
    // *****************************************************************
    // signals
    // *****************************************************************
    logic        CLK;
    logic        RESET_N;
    logic        START;
    logic [31:0] INSTR;
    logic [31:0] PROGRAM_STATUS_WORD;
    logic [3:0]  rd_addr;
    logic [15:0] rd_data;
    logic        wr_en;
    logic [3:0]  wr_addr;
    logic [15:0] wr_data;
    logic        BUSY;
    logic        DONE;
    logic        BRANCH_TAKEN;
    logic        ILLEGAL;
    logic [31:0] NEW_PSW;
    logic        ld_en;
    logic [3:0]  ld_addr;
    logic [15:0] ld_data;
    logic [15:0] regs [16];
    int          failures;
    int          samples_checked;
    logic [7:0]  ops [9] = '{OP_BF_BACK_SHORT, OP_BF_FWD_SHORT,
        OP_BF_REGISTER, OP_BF_INDEXED, OP_INDEX_HIGH, OP_INDEX_LOW_EQ,
        OP_CALL_REGISTER, OP_CALL_INDEXED, 8'h7E};

    branch_unit dut (
        .CLK(CLK), .RESET_N(RESET_N), .START(START), .INSTR(INSTR),
        .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD), .REG_RD_ADDR(rd_addr), .REG_RD_DATA(rd_data),
        .REG_WR_EN(wr_en), .REG_WR_ADDR(wr_addr), .REG_WR_DATA(wr_data),
        .BUSY(BUSY), .DONE(DONE), .BRANCH_TAKEN(BRANCH_TAKEN),
        .ILLEGAL(ILLEGAL), .NEW_PSW(NEW_PSW));

    reg_file_model partner (
        .clk(CLK), .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .ld_en(ld_en),
        .ld_addr(ld_addr), .ld_data(ld_data));

    // 20 MHz clock
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    // *****************************************************************
    // expectation and checking
    // *****************************************************************
    // reference behaviour, worked from the mirror of the register file
    function automatic void model(input logic [31:0] ins, program_status_word,
        output logic tk, ill, wr, output logic [15:0] nia, wd,
        output int lat);
        logic [3:0]  r1;
        logic [3:0]  f;
        logic [15:0] ia;
        logic [15:0] tgt;
        logic [15:0] sum;
        r1 = ins[23:20];
        f = ins[19:16];
        ia = program_status_word[15:0];
        tgt = ins[15:0] + ((f == 4'h0) ? 16'h0000 : regs[f]);
        tk = ((program_status_word[19:16] & r1) == 4'h0);
        ill = 1'b0;
        wr = 1'b0;
        wd = 16'h0000;
        lat = 2;
        sum = regs[r1] + regs[r1 + 4'h1];
        case (ins[31:24])
            OP_BF_BACK_SHORT: begin
                nia = tk ? ia - {11'h000, f, 1'b0} : ia + 16'h0002;
                lat = 1;
            end
            OP_BF_FWD_SHORT: begin
                nia = tk ? ia + {11'h000, f, 1'b0} : ia + 16'h0002;
                lat = 1;
            end
            OP_BF_REGISTER: nia = tk ? regs[f] : ia + 16'h0002;
            OP_BF_INDEXED: nia = tk ? tgt : ia + 16'h0004;
            OP_INDEX_HIGH, OP_INDEX_LOW_EQ: begin
                tk = ($signed(sum) > $signed(regs[r1 + 4'h2]));
                if (ins[24]) begin
                    tk = ~tk;
                end
                nia = tk ? tgt : ia + 16'h0004;
                wr = 1'b1;
                wd = sum;
                lat = 5;
            end
            OP_CALL_REGISTER: begin
                tk = 1'b1;
                nia = regs[f];
                wr = 1'b1;
                wd = ia + 16'h0002;
            end
            OP_CALL_INDEXED: begin
                tk = 1'b1;
                nia = tgt;
                wr = 1'b1;
                wd = ia + 16'h0004;
            end
            default: begin
                ill = 1'b1;
                tk = 1'b0;
                nia = ia;
                lat = 1;
            end
        endcase
    endfunction

    task automatic chk(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("wrong value at %0t ns: %s", $time, what);
        end
    endtask

    task automatic print_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // load the mirror, issue one instruction, check the answer
    task automatic run_op(input logic [31:0] ins, input logic [31:0] program_status_word);
        logic        tk;
        logic        ill;
        logic        wr;
        logic [15:0] nia;
        logic [15:0] wd;
        int          lat;
        int          cyc;
        model(ins, program_status_word, tk, ill, wr, nia, wd, lat);
        for (int i = 0; i < 16; i++) begin
            @(posedge CLK);
            ld_en <= 1'b1;
            ld_addr <= i[3:0];
            ld_data <= regs[i];
        end
        @(posedge CLK);
        ld_en <= 1'b0;
        START <= 1'b1;
        INSTR <= ins;
        PROGRAM_STATUS_WORD <= program_status_word;
        cyc = 0;
        // count from the edge that takes the request; a stray request
        // while busy must be dropped
        do begin
            @(posedge CLK);
            START <= (lat == 5 && cyc == 1);
            if (lat == 5 && cyc == 1) begin
                INSTR <= ~ins;
            end
            #1;
            cyc++;
        end while (DONE !== 1'b1 && cyc < 20);
        if (DONE !== 1'b1) begin
            failures++;
            print_verdict();
        end
        chk(cyc == lat, "answer latency");
        chk(NEW_PSW[31:16] === program_status_word[31:16], "status upper half");
        chk(NEW_PSW[15:0] === nia, "next");
        chk(ILLEGAL === ill, "illegal flag");
        chk(BRANCH_TAKEN === tk, "taken");
        chk(wr_en === wr, "write strobe");
        if (wr) begin
            chk(wr_addr === ins[23:20], "write address");
            chk(wr_data === wd, "write data");
        end
        @(posedge CLK);
        #1;
        chk(BUSY === 1'b0 && DONE === 1'b0, "idle after answer");
    endtask

    // *****************************************************************
    // main sequence
    // *****************************************************************
    initial begin
        logic [31:0] r;
        logic [31:0] p;
        failures = 0;
        samples_checked = 0;
        RESET_N = 1'b0;
        START = 1'b0;
        INSTR = 32'h00000000;
        PROGRAM_STATUS_WORD = 32'h00000000;
        ld_en = 1'b0;
        ld_addr = 4'h0;
        ld_data = 16'h0000;
        void'($urandom(32'h410b));
        for (int i = 0; i < 16; i++) begin
            regs[i] = 16'h0000;
        end
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        #1;
        chk(DONE === 1'b0 && BUSY === 1'b0 && wr_en === 1'b0, "reset");
        // corners: mask zero with address wrap, boundary displacements
        run_op(32'h220F0000, 32'h000F0010);
        run_op(32'h23F00000 | 32'h000F0000, 32'h0000FFF0);
        run_op(32'h22810000, 32'h00080100);
        run_op(32'h430F1234, 32'h000F0200);
        // count equal to limit, register numbers wrapping past 15
        regs[14] = 16'h0003;
        regs[15] = 16'h0002;
        regs[0] = 16'h0005;
        run_op(32'hC1E04000, 32'h00000300);
        run_op(32'hC0E04000, 32'h00000300);
        // count overflow wraps negative, so no branch
        regs[1] = 16'h7FFF;
        regs[2] = 16'h0001;
        regs[3] = 16'h0000;
        run_op(32'hC0105000, 32'h00000400);
        // link through the same register that holds the target
        regs[5] = 16'h0ABC;
        run_op(32'h01550000, 32'h00000500);
        run_op(32'h7E000000, 32'h00000600);
        // random traffic over every opcode
        for (int n = 0; n < 270; n++) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] = 16'($urandom());
            end
            r = $urandom();
            p = $urandom();
            run_op({ops[n % 9], r[23:0]}, p);
        end
        print_verdict();
    end
endmodule
